// >>> hdl/ref_cfg_cfg.svh
// Behaviour
// RULE1: Reference select bit 0 picks internal (1) or external (0) source.
// RULE2: Offset 0x24 holds all eight low bits of converter A's level code.
// RULE3: Offset 0x25 bit 0 holds code A's top bit; bits 7-1 reserved.
// RULE4: High bit and low byte join into 9-bit code A; 0x1ff gives 2.5 V.
// RULE5: Offset 0x26 holds all eight low bits of converter B's level code.
// RULE6: Offset 0x27 bit 0 holds code B's top bit; upper bits reserved.
// RULE7: High bit and low byte join into 9-bit code B; 0x1ff gives 2.5 V.
// RULE8: Input setup bit 1 selects range: 0 is 1x reference, 1 is 2x.
// RULE9: Input setup bit 0: single-ended (0) or pseudo-differential (1).
// RULE10: Reserved bits read as zero and ignore writes.
`ifndef REF_CFG_CFG_SVH
`define REF_CFG_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_REFERENCE_SOURCE_SELECT 8'h20
`define IDX_REF_LEVEL_A_LOW_BYTE 8'h24
`define IDX_REF_LEVEL_A_HIGH_BIT 8'h25
`define IDX_REF_LEVEL_B_LOW_BYTE 8'h26
`define IDX_REF_LEVEL_B_HIGH_BIT 8'h27
`define IDX_ANALOG_INPUT_SETUP 8'h28

// Implemented widths, fields start at bit 0
`define WIDTH_REFERENCE_SOURCE_SELECT 1
`define WIDTH_REF_LEVEL_LOW_BYTE 8
`define WIDTH_REF_LEVEL_HIGH_BIT 1
`define WIDTH_ANALOG_INPUT_SETUP 2

// Field positions
`define POS_REFERENCE_SOURCE_BIT 0
`define POS_REF_LEVEL_HIGH 0
`define POS_RANGE_DOUBLE 1
`define POS_PSEUDO_DIFF_ENABLE 0

// Reset values
`define RST_REFERENCE_SOURCE_SELECT 8'h00
`define RST_REF_LEVEL_A_LOW_BYTE 8'h00
`define RST_REF_LEVEL_A_HIGH_BIT 8'h00
`define RST_REF_LEVEL_B_LOW_BYTE 8'h00
`define RST_REF_LEVEL_B_HIGH_BIT 8'h00
`define RST_ANALOG_INPUT_SETUP 8'h00

// Bus encodings
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010
`define HRESP_OKAY 1'b0

`endif

// >>> hdl/ref_cfg_pkg.sv
package ref_cfg_pkg;

    // Gray order along idle, wait, done
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_REF_SOURCE = 3'h1,
        SEL_LEVEL_A_LOW = 3'h2,
        SEL_LEVEL_A_HIGH = 3'h3,
        SEL_LEVEL_B_LOW = 3'h4,
        SEL_LEVEL_B_HIGH = 3'h5,
        SEL_INPUT_SETUP = 3'h6
    } reg_sel_t;

    typedef logic [7:0] reg_byte_t;

endpackage : ref_cfg_pkg

// >>> hdl/cfg_byte_reg.sv
`timescale 1ns/100ps
module cfg_byte_reg
    import ref_cfg_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter reg_byte_t RESET_VALUE = 8'h00
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire reg_byte_t wr_data_in,
    output reg_byte_t value_out
);

    generate
        if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
            $error("cfg_byte_reg width must be 1 to 8");
        end
    endgenerate

    logic [WIDTH-1:0] stored;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stored <= RESET_VALUE[WIDTH-1:0];
        end else if (wr_en_in) begin
            stored <= wr_data_in[WIDTH-1:0]; // RULE10
        end
    end

    // Upper bits are not stored at all, so they read zero
    always_comb begin
        value_out = 8'h00;
        value_out[WIDTH-1:0] = stored; // RULE10
    end

endmodule : cfg_byte_reg

// >>> hdl/ref_code_join.sv
`timescale 1ns/100ps
`include "ref_cfg_cfg.svh"
module ref_code_join
    import ref_cfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire reg_byte_t low_byte_in,
    input wire reg_byte_t high_byte_in,
    output logic [8:0] code_out
);

    // Registered so the code pins come straight from flops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            code_out <= 9'h000;
        end else begin
            code_out <= {high_byte_in[`POS_REF_LEVEL_HIGH], low_byte_in};
        end
    end

endmodule : ref_code_join

// >>> hdl/adc_reference_input_config_regs.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "ref_cfg_cfg.svh"
module adc_reference_input_config_regs
    import ref_cfg_pkg::*;
#(
    parameter int REG_COUNT = 6
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic reference_source_bit_out,
    output logic [8:0] ref_level_code_a_out,
    output logic [8:0] ref_level_code_b_out,
    output logic range_double_out,
    output logic pseudo_diff_enable_bit_out
);

    generate
        if (REG_COUNT != 6) begin : g_bad_count
            $error("register bank is built for six registers");
        end
    endgenerate

    // Byte addresses of the registers
    localparam logic [9:0] ADDR_REF_SOURCE =
        {`IDX_REFERENCE_SOURCE_SELECT, 2'b00};
    localparam logic [9:0] ADDR_LEVEL_A_LOW =
        {`IDX_REF_LEVEL_A_LOW_BYTE, 2'b00};
    localparam logic [9:0] ADDR_LEVEL_A_HIGH =
        {`IDX_REF_LEVEL_A_HIGH_BIT, 2'b00};
    localparam logic [9:0] ADDR_LEVEL_B_LOW =
        {`IDX_REF_LEVEL_B_LOW_BYTE, 2'b00};
    localparam logic [9:0] ADDR_LEVEL_B_HIGH =
        {`IDX_REF_LEVEL_B_HIGH_BIT, 2'b00};
    localparam logic [9:0] ADDR_INPUT_SETUP =
        {`IDX_ANALOG_INPUT_SETUP, 2'b00};

    // A repeated index would alias two registers
    localparam logic [9:0] ADDR_LIST [REG_COUNT] = '{ADDR_REF_SOURCE,
        ADDR_LEVEL_A_LOW, ADDR_LEVEL_A_HIGH, ADDR_LEVEL_B_LOW,
        ADDR_LEVEL_B_HIGH, ADDR_INPUT_SETUP};
    generate
        for (genvar a = 0; a < REG_COUNT; a++) begin : g_addr_chk
            for (genvar b = a + 1; b < REG_COUNT; b++) begin : g_pair
                if (ADDR_LIST[a] == ADDR_LIST[b]) begin : g_dup
                    $error("two registers share one address");
                end
            end
        end
    endgenerate

    // Slot numbers in the register array
    localparam int SLOT_REF_SOURCE = 0;
    localparam int SLOT_LEVEL_A_LOW = 1;
    localparam int SLOT_LEVEL_A_HIGH = 2;
    localparam int SLOT_LEVEL_B_LOW = 3;
    localparam int SLOT_LEVEL_B_HIGH = 4;
    localparam int SLOT_INPUT_SETUP = 5;

    // Decode a byte address to a register select
    function automatic reg_sel_t decode_addr(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:10] == 22'h000000) begin
            case (addr[9:0])
                ADDR_REF_SOURCE: begin
                    sel = SEL_REF_SOURCE;
                end
                ADDR_LEVEL_A_LOW: begin
                    sel = SEL_LEVEL_A_LOW;
                end
                ADDR_LEVEL_A_HIGH: begin
                    sel = SEL_LEVEL_A_HIGH;
                end
                ADDR_LEVEL_B_LOW: begin
                    sel = SEL_LEVEL_B_LOW;
                end
                ADDR_LEVEL_B_HIGH: begin
                    sel = SEL_LEVEL_B_HIGH;
                end
                ADDR_INPUT_SETUP: begin
                    sel = SEL_INPUT_SETUP;
                end
                default: begin
                    sel = SEL_NONE;
                end
            endcase
        end
        return sel;
    endfunction : decode_addr

    // Slot number in the register array for a select
    function automatic logic [2:0] slot_of(input reg_sel_t sel);
        logic [2:0] slot;
        slot = 3'h0;
        case (sel)
            SEL_REF_SOURCE: begin
                slot = 3'h0;
            end
            SEL_LEVEL_A_LOW: begin
                slot = 3'h1;
            end
            SEL_LEVEL_A_HIGH: begin
                slot = 3'h2;
            end
            SEL_LEVEL_B_LOW: begin
                slot = 3'h3;
            end
            SEL_LEVEL_B_HIGH: begin
                slot = 3'h4;
            end
            SEL_INPUT_SETUP: begin
                slot = 3'h5;
            end
            default: begin
                slot = 3'h0;
            end
        endcase
        return slot;
    endfunction : slot_of

    // Implemented width of each slot
    function automatic int slot_width(input int slot);
        int w;
        w = 8;
        case (slot)
            0: begin
                w = `WIDTH_REFERENCE_SOURCE_SELECT;
            end
            1, 3: begin
                w = `WIDTH_REF_LEVEL_LOW_BYTE;
            end
            2, 4: begin
                w = `WIDTH_REF_LEVEL_HIGH_BIT;
            end
            5: begin
                w = `WIDTH_ANALOG_INPUT_SETUP;
            end
            default: begin
                w = 8;
            end
        endcase
        return w;
    endfunction : slot_width

    // Reset value of each slot
    function automatic reg_byte_t slot_reset(input int slot);
        reg_byte_t r;
        r = 8'h00;
        case (slot)
            0: begin
                r = `RST_REFERENCE_SOURCE_SELECT;
            end
            1: begin
                r = `RST_REF_LEVEL_A_LOW_BYTE;
            end
            2: begin
                r = `RST_REF_LEVEL_A_HIGH_BIT;
            end
            3: begin
                r = `RST_REF_LEVEL_B_LOW_BYTE;
            end
            4: begin
                r = `RST_REF_LEVEL_B_HIGH_BIT;
            end
            5: begin
                r = `RST_ANALOG_INPUT_SETUP;
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return r;
    endfunction : slot_reset

    // Reserved bits must come out of reset as zero
    generate
        for (genvar s = 0; s < REG_COUNT; s++) begin : g_rst_chk
            if ((slot_reset(s) >> slot_width(s)) != 8'h00) begin : g_bad
                $error("reset value sets a reserved bit"); // RULE10
            end
        end
    endgenerate

    bus_state_t state;
    bus_state_t next_state;
    logic accept;
    reg_sel_t held_sel;
    logic held_write;
    logic held_word;
    logic [REG_COUNT-1:0] wr_en;
    reg_byte_t reg_value [REG_COUNT];
    reg_byte_t read_byte;

    // Address phase taken only while the bus is ready
    assign accept = hsel_in && hready_in &&
        (htrans_in == `HTRANS_NONSEQ);

    // One wait state on every transfer: write lands, then read
    // data is registered from settled contents, so a read right
    // after a write always sees it
    always_comb begin
        next_state = state;
        case (state)
            BUS_IDLE: begin
                if (accept) begin
                    next_state = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                next_state = BUS_DONE;
            end
            BUS_DONE: begin
                if (accept) begin
                    next_state = BUS_WAIT;
                end else begin
                    next_state = BUS_IDLE;
                end
            end
            default: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hreadyout_out <= 1'b1;
        end else begin
            hreadyout_out <= (next_state != BUS_WAIT);
        end
    end

    // Every transfer answers OKAY, unmapped ones too
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hresp_out <= `HRESP_OKAY;
        end else begin
            hresp_out <= `HRESP_OKAY;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            held_sel <= SEL_NONE;
            held_write <= 1'b0;
            held_word <= 1'b0;
        end else if (accept) begin
            held_sel <= decode_addr(haddr_in);
            held_write <= hwrite_in;
            held_word <= (hsize_in == `HSIZE_WORD);
        end
    end

    // Registers: write in the wait cycle, narrower sizes ignored
    generate
        for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
            assign wr_en[i] = (state == BUS_WAIT) && held_write &&
                held_word && (held_sel != SEL_NONE) &&
                (slot_of(held_sel) == 3'(i));
            cfg_byte_reg #(
                .WIDTH(slot_width(i)),
                .RESET_VALUE(slot_reset(i))
            ) u_reg (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .wr_en_in(wr_en[i]),
                .wr_data_in(hwdata_in[7:0]), // RULE2 RULE5 RULE10
                .value_out(reg_value[i])
            );
        end
    endgenerate

    // Unmapped addresses read zero
    always_comb begin
        read_byte = 8'h00;
        if (held_sel != SEL_NONE) begin
            read_byte = reg_value[slot_of(held_sel)]; // RULE10
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h00000000;
        end else if (state == BUS_WAIT && !held_write) begin
            hrdata_out <= {24'h000000, read_byte};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reference_source_bit_out <= 1'b0;
        end else begin
            reference_source_bit_out <=
                reg_value[SLOT_REF_SOURCE][`POS_REFERENCE_SOURCE_BIT]; // RULE1
        end
    end

    // Code A pins follow one cycle after either half is written
    ref_code_join u_code_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .low_byte_in(reg_value[SLOT_LEVEL_A_LOW]), // RULE2
        .high_byte_in(reg_value[SLOT_LEVEL_A_HIGH]), // RULE3
        .code_out(ref_level_code_a_out) // RULE4
    );

    ref_code_join u_code_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .low_byte_in(reg_value[SLOT_LEVEL_B_LOW]), // RULE5
        .high_byte_in(reg_value[SLOT_LEVEL_B_HIGH]), // RULE6
        .code_out(ref_level_code_b_out) // RULE7
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            range_double_out <= 1'b0;
        end else begin
            range_double_out <=
                reg_value[SLOT_INPUT_SETUP][`POS_RANGE_DOUBLE]; // RULE8
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pseudo_diff_enable_bit_out <= 1'b0;
        end else begin
            pseudo_diff_enable_bit_out <=
                reg_value[SLOT_INPUT_SETUP][`POS_PSEUDO_DIFF_ENABLE]; // RULE9
        end
    end

endmodule : adc_reference_input_config_regs

// >>> dv/cfg_regs_checker.sv
`timescale 1ns/100ps
module cfg_regs_checker #(
    parameter int REG_COUNT = 6
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic reference_source_bit_out,
    input wire logic [8:0] ref_level_code_a_out,
    input wire logic [8:0] ref_level_code_b_out,
    input wire logic range_double_out,
    input wire logic pseudo_diff_enable_bit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic taken;
    logic wr_word;
    assign taken = hsel_in && hready_in && htrans_in == 2'b10;
    // Only word writes commit
    assign wr_word = taken && hwrite_in && hsize_in == 3'b010;

    a_resp_okay: assert property (!hresp_out)
        else $error("response not okay");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_wait_one: assert property (taken |=> !hreadyout_out ##1 hreadyout_out)
        else $error("wait state count wrong");
    a_ref_write: assert property (
        wr_word && haddr_in == 32'h80 |=> ##2
        reference_source_bit_out == $past(hwdata_in[0]))
        else $error("reference source not written");
    a_low_a: assert property (
        wr_word && haddr_in == 32'h90 |=> ##2
        ref_level_code_a_out[7:0] == $past(hwdata_in[7:0]))
        else $error("code a low byte not written");
    a_high_a: assert property (
        wr_word && haddr_in == 32'h94 |=> ##2
        ref_level_code_a_out[8] == $past(hwdata_in[0]))
        else $error("code a high bit not written");
    a_low_b: assert property (
        wr_word && haddr_in == 32'h98 |=> ##2
        ref_level_code_b_out[7:0] == $past(hwdata_in[7:0]))
        else $error("code b low byte not written");
    a_high_b: assert property (
        wr_word && haddr_in == 32'h9c |=> ##2
        ref_level_code_b_out[8] == $past(hwdata_in[0]))
        else $error("code b high bit not written");
    a_setup_write: assert property (
        wr_word && haddr_in == 32'ha0 |=> ##2
        {range_double_out, pseudo_diff_enable_bit_out}
        == $past(hwdata_in[1:0]))
        else $error("input setup not written");
    a_outs_hold: assert property (
        !$past(wr_word, 3) |-> $stable(ref_level_code_a_out)
        && $stable(ref_level_code_b_out) && $stable(range_double_out)
        && $stable(reference_source_bit_out)
        && $stable(pseudo_diff_enable_bit_out))
        else $error("config changed without write");
    a_read_ref: assert property (
        taken && !hwrite_in && haddr_in == 32'h80 |=> ##1
        hrdata_out == {31'h0, reference_source_bit_out})
        else $error("reference source readback wrong");
endmodule : cfg_regs_checker

bind adc_reference_input_config_regs cfg_regs_checker #(
    .REG_COUNT(REG_COUNT)
) chk (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .reference_source_bit_out(reference_source_bit_out),
    .ref_level_code_a_out(ref_level_code_a_out),
    .ref_level_code_b_out(ref_level_code_b_out),
    .range_double_out(range_double_out),
    .pseudo_diff_enable_bit_out(pseudo_diff_enable_bit_out)
);

// >>> dv/ahb_host.sv
`timescale 1ns/100ps
module ahb_host (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'b00;
        hwrite_out = 1'b0;
        hsize_out = 3'b010;
        hwdata_out = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [31:0] addr,
                        input logic [31:0] data, input logic [2:0] size,
                        output logic [31:0] rdata);
        @(posedge clk_in);
        hsel_out <= 1'b1;
        haddr_out <= addr;
        htrans_out <= 2'b10;
        hwrite_out <= wr;
        hsize_out <= size;
        do @(posedge clk_in); while (!hready_in);
        hsel_out <= 1'b0;
        htrans_out <= 2'b00;
        hwdata_out <= data;
        do @(posedge clk_in); while (!hready_in);
        rdata = hrdata_in;
        // Stale data inverted so a late sample cannot match
        hwdata_out <= ~data;
    endtask : xfer
endmodule : ahb_host

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, ref_src, rng, pdiff;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [8:0] code_a, code_b;
    logic [7:0] sh [6];
    logic [7:0] val;
    int i;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [7:0] OFF [6] = '{8'h20, 8'h24, 8'h25, 8'h26,
                                       8'h27, 8'h28};
    localparam logic [7:0] MASK [6] = '{8'h01, 8'hff, 8'h01, 8'hff,
                                        8'h01, 8'h03};

    ahb_host host (.clk_in(clk_in), .hready_in(hreadyout),
        .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
        .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata));

    adc_reference_input_config_regs dut (.clk_in(clk_in), .rst_in(rst_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(hresp),
        .reference_source_bit_out(ref_src), .ref_level_code_a_out(code_a),
        .ref_level_code_b_out(code_b), .range_double_out(rng),
        .pseudo_diff_enable_bit_out(pdiff));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [31:0] adr(input int k);
        return {22'h0, OFF[k], 2'b00};
    endfunction : adr

    function automatic logic [31:0] outs();
        return {11'h0, ref_src, code_a, code_b, rng, pdiff};
    endfunction : outs

    function automatic logic [31:0] expo();
        return {11'h0, sh[0][0], sh[2][0], sh[1], sh[4][0], sh[3],
                sh[5][1:0]};
    endfunction : expo

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Counts: %0d mismatches, %0d compares", bad_count,
                 n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // Ceiling well above the roughly 440 cycles the run needs
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        rd = $urandom(51);
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check(outs(), 32'h0);
        for (int k = 0; k < 6; k++) begin
            host.xfer(1'b0, adr(k), 32'h0, 3'b010, rd);
            check(rd, 32'h0);
            sh[k] = 8'h00;
        end
        // First six writes set every bit, upper junk included
        for (int n = 0; n < 46; n++) begin
            i = (n < 6) ? n : $urandom % 6;
            val = (n < 6) ? 8'hff : 8'($urandom);
            host.xfer(1'b1, adr(i), {24'hffffff, val}, 3'b010, rd);
            sh[i] = val & MASK[i];
            host.xfer(1'b0, adr(i), 32'h0, 3'b010, rd);
            check(rd, {24'h0, sh[i]});
            check(outs(), expo());
            if (n == 5) begin
                check({14'h0, code_a, code_b}, 32'h3ffff);
            end
        end
        // Reset mid-run must clear every register and pin
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check(outs(), 32'h0);
        for (int k = 0; k < 6; k++) begin
            sh[k] = 8'h00;
            host.xfer(1'b0, adr(k), 32'h0, 3'b010, rd);
            check(rd, 32'h0);
        end
        host.xfer(1'b1, adr(1), 32'h5a, 3'b000, rd);
        host.xfer(1'b1, 32'h84, 32'hff, 3'b010, rd);
        host.xfer(1'b0, 32'h84, 32'h0, 3'b010, rd);
        check(rd, 32'h0);
        check(outs(), expo());
        conclude();
    end
endmodule : tb_top
